// ===== shared/i2c_regs_pkg.sv
package i2c_regs_pkg;

  // Slave address: reloadable upper five bits, then two strap bits.
  localparam logic [4:0] ADDR_HI_RST    = 5'h08;
  localparam logic [7:0] GC_ADDR        = 8'h00;
  localparam logic [7:0] GC_SWRESET     = 8'h06;
  localparam logic [7:0] GC_RELOAD      = 8'h04;
  localparam logic [7:0] ADDR_CFG_REG   = 8'hCA;
  localparam int         ADDR_CFG_LSB   = 2;
  localparam int         ADDR_CFG_MSB   = 6;

  // Register space and special locations.
  localparam int         REG_DEPTH      = 256;
  localparam logic [7:0] EE_ADDR_REG    = 8'h11;
  localparam logic [7:0] EE_DATA_REG    = 8'h12;
  localparam logic [7:0] SHUTTER_REG    = 8'hA4;
  localparam logic [7:0] SHADOW_LO      = 8'h90;
  localparam logic [7:0] SHADOW_HI      = 8'h9F;

  // Bit counting and reset values.
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [1:0] STRAP_SETTLE   = 2'h3;
  localparam logic [1:0] STRAP_RST      = 2'h0;

  // Timing.
  localparam int         CORE_CLK_HZ    = 40_000_000;
  localparam int         EE_WRITE_MS    = 20;
  localparam int         EE_WRITE_CYC   = (CORE_CLK_HZ / 1000) * EE_WRITE_MS;
  localparam int         EE_CNT_W       = 20;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_ACK    = 3'h3,
    ST_RX     = 3'h2,
    ST_TX     = 3'h6,
    ST_TACK   = 3'h7,
    ST_IGNORE = 3'h4
  } i2c_state_e;

  typedef struct packed {
    logic       wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic       rdEn;
    logic [7:0] rdAddr;
  } mem_req_s;

endpackage

// ===== verilog/reg_file_256x8.sv
`timescale 1ns/100ps
module reg_file_256x8
  import i2c_regs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire mem_req_s   memReq,
  output logic      [7:0] rdData
);

  logic [7:0] regMem [REG_DEPTH];
  logic [7:0] rdData_ff;

  always_ff @(posedge core_clk) begin
    if (memReq.wrEn) begin
      regMem[memReq.wrAddr] <= memReq.wrData;
    end
    if (memReq.rdEn) begin
      rdData_ff <= regMem[memReq.rdAddr];
    end
  end

  assign rdData = rdData_ff;

endmodule

// ===== verilog/scl_bit_capture.sv
`timescale 1ns/100ps
module scl_bit_capture
  import i2c_regs_pkg::*;
(
  input  wire logic       sclClk,
  input  wire logic       sdaIn,
  output logic      [7:0] rxShift
);

  // Shifts SDA in on each SCL rise; the core reads it only after its own
  // synchronised view of that rise, when the value has long been stable.
  typedef struct packed {
    logic [7:0] shift;
  } link_s;

  link_s st_ff;
  link_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.shift = {st_ff.shift[6:0], sdaIn};
  end

  always_ff @(posedge sclClk) begin
    st_ff <= nxt_st;
  end

  assign rxShift = st_ff.shift;

endmodule

// ===== verilog/i2c_register_access_slave.sv
`timescale 1ns/100ps
// Operation
// [RULE1] Only 7-bit slave addressing is accepted.
// [RULE2] Slave may stretch SCL; master waits.
// [RULE3] General call 0x06 performs full reset.
// [RULE4] General call 0x04 reloads address bits.
// [RULE5] General calls keep strap-captured low bits.
// [RULE6] Address is 01000, strap one, zero.
// [RULE7] Open straps read as zero.
// [RULE8] System pulls straps high for distinct addresses.
// [RULE9] Follows any SCL rate without setup.
// [RULE10] Master writes address, register, data, stop.
// [RULE11] Data bytes stored, pointer then increments.
// [RULE12] Master stays within register address space.
// [RULE13] Single read ends with NACK, stop.
// [RULE14] Reads continue until master does NACK.
// [RULE15] Unshadowed registers written outside acquisition.
// [RULE16] Shadowed writes take effect next frame.
// [RULE17] Shutter register write starts acquisition.
// [RULE18] Write is three bytes, read four.
// [RULE19] Nonvolatile write takes about twenty milliseconds.
// [RULE20] Unsupported bus usage is ignored.
// [RULE21] Register space is 256 eight-bit locations.
// [RULE22] Multi-byte registers are MSB first.
// [RULE23] Acknowledge own address and bytes only.
// [RULE24] Written register address loads shared pointer.
module i2c_register_access_slave
  import i2c_regs_pkg::*;
#(
  parameter int EE_WRITE_CYCLES = EE_WRITE_CYC
) (
  input  wire logic     core_clk,
  input  wire logic     sys_rst,
  input  wire logic     sclClk,
  input  wire logic     sclIn,
  output logic          sclOut,
  output logic          sclOe,
  input  wire logic     sdaIn,
  output logic          sdaOut,
  output logic          sdaOe,
  input  wire logic     addr_strap_bit_zero,
  input  wire logic     addr_strap_bit_one,
  input  wire logic     acqBusy,
  input  wire logic     frameStart,
  output logic          shutterStart,
  output logic          shadowLoad,
  output logic          swResetReq,
  output logic          eeWriteStart,
  output logic          eeBusy,
  output mem_req_s      regAccess
);

  typedef struct packed {
    i2c_state_e          state;
    logic [2:0]          bitCnt;
    logic [1:0]          sclSync;
    logic [1:0]          sdaSync;
    logic [1:0]          strapMeta;
    logic [1:0]          strapSyncd;
    logic                sclPrev;
    logic                sdaPrev;
    logic [1:0]          strap;
    logic [1:0]          strapCnt;
    logic                strapDone;
    logic [4:0]          addrHi;
    logic [7:0]          ptr;
    logic [7:0]          rxByte;
    logic [7:0]          txByte;
    logic                txValid;
    logic                rdPend;
    logic                cfgPend;
    logic                needDrive;
    logic                ackArm;
    logic                ackOn;
    logic                pendWr;
    logic                gcExec;
    logic                isRead;
    logic                gcall;
    logic                regPhase;
    mem_req_s            mem;
    logic                sdaOe;
    logic                sclOe;
    logic                shutterStart;
    logic                shadowLoad;
    logic                shadowPend;
    logic                swResetReq;
    logic                eeWriteStart;
    logic                eeBusy;
    logic [EE_CNT_W-1:0] eeCnt;
  } core_s;

  core_s      st_ff;
  core_s      nxt_st;
  logic [7:0] linkShift;
  logic [7:0] rdData;
  logic       sclRise;
  logic       sclFall;
  logic       startEv;
  logic       stopEv;
  logic [6:0] slaveAddr;

  function automatic mem_req_s memRd(input logic [7:0] addr);
    mem_req_s req;
    req        = '0;
    req.rdEn   = 1'b1;
    req.rdAddr = addr;
    return req;
  endfunction

  function automatic logic isShadow(input logic [7:0] addr);
    return (addr >= SHADOW_LO) && (addr <= SHADOW_HI);
  endfunction

  scl_bit_capture u_link (
    .sclClk  (sclClk),
    .sdaIn   (sdaIn),
    .rxShift (linkShift)
  );

  reg_file_256x8 u_regs (
    .core_clk (core_clk),
    .memReq   (st_ff.mem),
    .rdData   (rdData)
  );

  // Bus events come from synchronised pin levels, so no rate setup is needed.
  assign sclRise   = st_ff.sclSync[1] & ~st_ff.sclPrev;             // [RULE9]
  assign sclFall   = ~st_ff.sclSync[1] & st_ff.sclPrev;
  assign startEv   = st_ff.sclSync[1] & st_ff.sclPrev & st_ff.sdaPrev & ~st_ff.sdaSync[1];
  assign stopEv    = st_ff.sclSync[1] & st_ff.sclPrev & ~st_ff.sdaPrev & st_ff.sdaSync[1];
  assign slaveAddr = {st_ff.addrHi, st_ff.strap};                   // [RULE6]

  always_comb begin
    logic doSwReset;
    doSwReset = 1'b0;
    nxt_st = st_ff;
    nxt_st.mem          = '0;
    nxt_st.shutterStart = 1'b0;
    nxt_st.shadowLoad   = 1'b0;
    nxt_st.swResetReq   = 1'b0;
    nxt_st.eeWriteStart = 1'b0;
    nxt_st.sclSync      = {st_ff.sclSync[0], sclIn};                // [RULE9]
    nxt_st.sdaSync      = {st_ff.sdaSync[0], sdaIn};
    nxt_st.strapMeta    = {addr_strap_bit_one, addr_strap_bit_zero};
    nxt_st.strapSyncd   = st_ff.strapMeta;
    nxt_st.sclPrev      = st_ff.sclSync[1];
    nxt_st.sdaPrev      = st_ff.sdaSync[1];

    // Straps are scanned once, a few cycles after reset release.
    if (!st_ff.strapDone) begin
      nxt_st.strapCnt = st_ff.strapCnt + 2'h1;
      if (st_ff.strapCnt == STRAP_SETTLE) begin
        nxt_st.strap     = st_ff.strapSyncd;                        // [RULE7]
        nxt_st.strapDone = 1'b1;
      end
    end

    // Read data leave the register file one cycle after the request does.
    if (st_ff.rdPend && !st_ff.mem.rdEn) begin
      nxt_st.rdPend  = 1'b0;
      nxt_st.txByte  = rdData;
      nxt_st.txValid = 1'b1;
    end
    // Only the upper address bits are reloaded; strap bits stay as scanned.
    if (st_ff.cfgPend && !st_ff.mem.rdEn) begin
      nxt_st.cfgPend = 1'b0;
      nxt_st.addrHi  = rdData[ADDR_CFG_MSB:ADDR_CFG_LSB];           // [RULE4] [RULE5]
    end

    if (st_ff.eeCnt != '0) begin
      nxt_st.eeCnt = st_ff.eeCnt - EE_CNT_W'(1);
    end
    if (frameStart && st_ff.shadowPend) begin
      nxt_st.shadowLoad = 1'b1;                                     // [RULE16]
      nxt_st.shadowPend = 1'b0;
    end

    if (startEv || stopEv) begin
      nxt_st.state     = startEv ? ST_ADDR : ST_IDLE;
      nxt_st.bitCnt    = '0;
      nxt_st.sdaOe     = 1'b0;
      nxt_st.sclOe     = 1'b0;
      nxt_st.ackArm    = 1'b0;
      nxt_st.ackOn     = 1'b0;
      nxt_st.pendWr    = 1'b0;
      nxt_st.gcExec    = 1'b0;
      nxt_st.gcall     = 1'b0;
      nxt_st.needDrive = 1'b0;
    end else begin
      unique case (st_ff.state)
        ST_IDLE, ST_IGNORE: begin
          nxt_st.sdaOe = 1'b0;
          nxt_st.sclOe = 1'b0;
        end
        ST_ADDR: begin
          if (sclRise) begin
            nxt_st.bitCnt = st_ff.bitCnt + 3'h1;
            if (st_ff.bitCnt == LAST_BIT) begin
              if (linkShift[7:1] == slaveAddr) begin                // [RULE1] [RULE23]
                nxt_st.state    = ST_ACK;
                nxt_st.isRead   = linkShift[0];
                nxt_st.regPhase = ~linkShift[0];                    // [RULE18]
                if (linkShift[0]) begin
                  nxt_st.mem     = memRd(st_ff.ptr);                // [RULE24]
                  nxt_st.rdPend  = 1'b1;
                  nxt_st.txValid = 1'b0;
                end
              end else if (linkShift == GC_ADDR) begin
                nxt_st.state  = ST_ACK;
                nxt_st.gcall  = 1'b1;
                nxt_st.isRead = 1'b0;
              end else begin
                nxt_st.state = ST_IGNORE;                           // [RULE23]
              end
            end
          end
        end
        ST_RX: begin
          if (sclRise) begin
            nxt_st.bitCnt = st_ff.bitCnt + 3'h1;
            if (st_ff.bitCnt == LAST_BIT) begin
              nxt_st.rxByte = linkShift;
              if (st_ff.gcall) begin
                if ((linkShift == GC_SWRESET) || (linkShift == GC_RELOAD)) begin
                  nxt_st.state  = ST_ACK;                           // [RULE3] [RULE4]
                  nxt_st.gcExec = 1'b1;
                end else begin
                  nxt_st.state = ST_IGNORE;                         // [RULE20]
                end
              end else if (st_ff.regPhase) begin
                nxt_st.ptr      = linkShift;                        // [RULE24] [RULE21]
                nxt_st.regPhase = 1'b0;
                nxt_st.state    = ST_ACK;
              end else begin
                nxt_st.pendWr = 1'b1;                               // [RULE11]
                nxt_st.state  = ST_ACK;
              end
            end
          end
        end
        ST_ACK: begin
          if (sclFall && !st_ff.ackOn) begin
            nxt_st.ackArm = 1'b1;
          end
          if (st_ff.ackArm) begin
            // A write to the nonvolatile access pair waits for the last one.
            if (st_ff.pendWr && st_ff.eeBusy &&
                ((st_ff.ptr == EE_ADDR_REG) || (st_ff.ptr == EE_DATA_REG))) begin
              nxt_st.sclOe = 1'b1;                                  // [RULE2]
            end else begin
              if (st_ff.pendWr) begin
                nxt_st.pendWr     = 1'b0;
                nxt_st.mem.wrEn   = 1'b1;                           // [RULE11]
                nxt_st.mem.wrAddr = st_ff.ptr;
                nxt_st.mem.wrData = st_ff.rxByte;
                nxt_st.ptr        = st_ff.ptr + 8'h1;               // [RULE22]
                if (st_ff.ptr == SHUTTER_REG) begin
                  nxt_st.shutterStart = 1'b1;                       // [RULE17]
                end
                if (isShadow(st_ff.ptr)) begin
                  if (acqBusy) begin
                    nxt_st.shadowPend = 1'b1;                       // [RULE16]
                  end else begin
                    nxt_st.shadowLoad = 1'b1;
                  end
                end
                if (st_ff.ptr == EE_DATA_REG) begin
                  nxt_st.eeWriteStart = 1'b1;                       // [RULE19]
                  nxt_st.eeCnt        = EE_CNT_W'(EE_WRITE_CYCLES);
                end
              end
              nxt_st.sdaOe  = 1'b1;                                 // [RULE23]
              nxt_st.ackArm = 1'b0;
              nxt_st.ackOn  = 1'b1;
            end
          end
          // A stretched clock is let go one cycle after SDA is driven.
          if (st_ff.ackOn) begin
            nxt_st.sclOe = 1'b0;                                    // [RULE2]
          end
          if (sclFall && st_ff.ackOn) begin
            nxt_st.sdaOe  = 1'b0;
            nxt_st.ackOn  = 1'b0;
            nxt_st.bitCnt = '0;
            if (st_ff.gcExec) begin
              nxt_st.gcExec = 1'b0;
              nxt_st.state  = ST_IGNORE;
              if (st_ff.rxByte == GC_SWRESET) begin
                doSwReset = 1'b1;                                   // [RULE3]
              end else begin
                nxt_st.mem     = memRd(ADDR_CFG_REG);               // [RULE4]
                nxt_st.cfgPend = 1'b1;
              end
            end else if (st_ff.isRead) begin
              nxt_st.state     = ST_TX;
              nxt_st.needDrive = 1'b1;
            end else begin
              nxt_st.state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            nxt_st.needDrive = 1'b1;
          end
          // Hold SCL low until the byte to send is back from the register file.
          if (st_ff.needDrive) begin
            if (st_ff.txValid) begin
              nxt_st.sdaOe     = ~st_ff.txByte[~st_ff.bitCnt];      // [RULE22]
              nxt_st.needDrive = 1'b0;
            end else begin
              nxt_st.sclOe = 1'b1;                                  // [RULE2]
            end
          end else begin
            nxt_st.sclOe = 1'b0;
          end
          if (sclRise) begin
            nxt_st.bitCnt = st_ff.bitCnt + 3'h1;
            if (st_ff.bitCnt == LAST_BIT) begin
              nxt_st.state   = ST_TACK;
              nxt_st.txValid = 1'b0;
            end
          end
        end
        ST_TACK: begin
          if (sclFall) begin
            nxt_st.sdaOe = 1'b0;
          end
          if (sclRise) begin
            if (!linkShift[0]) begin
              nxt_st.ptr    = st_ff.ptr + 8'h1;                     // [RULE14]
              nxt_st.mem    = memRd(st_ff.ptr + 8'h1);
              nxt_st.rdPend = 1'b1;
              nxt_st.bitCnt = '0;
              nxt_st.state  = ST_TX;
            end else begin
              nxt_st.state = ST_IGNORE;                             // [RULE13] [RULE18]
            end
          end
        end
        default: begin
          nxt_st.state = ST_IDLE;
        end
      endcase
    end

    // A software reset returns everything to its reset value except the
    // scanned straps and the pin synchronisers.
    if (doSwReset) begin
      nxt_st            = '0;                                       // [RULE3] [RULE5]
      nxt_st.addrHi     = ADDR_HI_RST;
      nxt_st.strap      = st_ff.strap;
      nxt_st.strapCnt   = st_ff.strapCnt;
      nxt_st.strapDone  = st_ff.strapDone;
      nxt_st.sclSync    = st_ff.sclSync;
      nxt_st.sdaSync    = st_ff.sdaSync;
      nxt_st.strapMeta  = st_ff.strapMeta;
      nxt_st.strapSyncd = st_ff.strapSyncd;
      nxt_st.sclPrev    = st_ff.sclPrev;
      nxt_st.sdaPrev    = st_ff.sdaPrev;
      nxt_st.swResetReq = 1'b1;
    end

    nxt_st.eeBusy = (nxt_st.eeCnt != '0);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff        <= '0;
      st_ff.addrHi <= ADDR_HI_RST;                                  // [RULE6]
      st_ff.strap  <= STRAP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sclOut       = 1'b0;
  assign sdaOut       = 1'b0;
  assign sclOe        = st_ff.sclOe;
  assign sdaOe        = st_ff.sdaOe;
  assign shutterStart = st_ff.shutterStart;
  assign shadowLoad   = st_ff.shadowLoad;
  assign swResetReq   = st_ff.swResetReq;
  assign eeWriteStart = st_ff.eeWriteStart;
  assign eeBusy       = st_ff.eeBusy;
  assign regAccess    = st_ff.mem;

endmodule

// ===== dv/i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model (
  output logic      sclLow,
  output logic      sdaLow,
  input  wire logic sclWire,
  input  wire logic sdaWire
);
  // Quarter step: SCL is low for four steps and high for two within a frame.
  localparam realtime TQ = 62.5;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // SDA moves a step after the fall so that no edge looks like START or STOP.
  task automatic bitx(input logic b, output logic s);
    #(TQ);
    sdaLow = !b;
    #(3*TQ);
    sclLow = 1'b0;
    wait (sclWire === 1'b1);
    s = sdaWire;
    #(2*TQ);
    sclLow = 1'b1;
  endtask
  task automatic start();
    #(2*TQ);
    sdaLow = 1'b0;
    #(TQ);
    sclLow = 1'b0;
    wait (sclWire === 1'b1);
    #(2*TQ);
    sdaLow = 1'b1;
    #(2*TQ);
    sclLow = 1'b1;
  endtask
  task automatic stop();
    #(2*TQ);
    sdaLow = 1'b1;
    #(TQ);
    sclLow = 1'b0;
    wait (sclWire === 1'b1);
    #(2*TQ);
    sdaLow = 1'b0;
    #(4*TQ);
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], s);
    end
    bitx(1'b1, s);
    ack = !s;
  endtask
  task automatic rdByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(!ack, s);
  endtask
endmodule

// ===== dv/i2c_slave_props.sv
`timescale 1ns/100ps
module i2c_slave_props
  import i2c_regs_pkg::*;
#(
  parameter int EE_WRITE_CYCLES = 50
) (
  input wire logic     core_clk,
  input wire logic     sys_rst,
  input wire logic     sclOut,
  input wire logic     sclOe,
  input wire logic     sdaOut,
  input wire logic     sdaOe,
  input wire logic     acqBusy,
  input wire logic     frameStart,
  input wire logic     shutterStart,
  input wire logic     shadowLoad,
  input wire logic     swResetReq,
  input wire logic     eeWriteStart,
  input wire logic     eeBusy,
  input wire mem_req_s regAccess
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [19:0] busyCnt_ff;
  always_ff @(posedge core_clk) begin
    busyCnt_ff <= (eeBusy && !sys_rst) ? busyCnt_ff + 20'h1 : 20'h0;
  end
  sequence eeLaunch;
    eeWriteStart ##1 eeBusy;
  endsequence
  sequence eeRelease;
    !eeBusy ##[0:6] !sclOe;
  endsequence
  a_open_drain: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("SCL or SDA driven high");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !sdaOe && !sclOe && !eeBusy)
    else $error("outputs active after reset");
  a_swreset_clears: assert property (swResetReq |=> !eeBusy && !shutterStart)
    else $error("state kept after software reset");
  a_shutter_write: assert property (regAccess.wrEn && regAccess.wrAddr == SHUTTER_REG
    |-> ##[0:2] shutterStart)
    else $error("shutter write without start");
  a_write_pulse: assert property (regAccess.wrEn |=> !regAccess.wrEn)
    else $error("write strobe longer than one cycle");
  a_ee_launch: assert property (eeWriteStart |-> eeLaunch)
    else $error("nonvolatile write not busy");
  a_ee_length: assert property ($fell(eeBusy) |-> busyCnt_ff >= EE_WRITE_CYCLES - 1
    && busyCnt_ff <= EE_WRITE_CYCLES + 1)
    else $error("nonvolatile busy time wrong");
  a_stretch_release: assert property ($fell(eeBusy) |-> eeRelease)
    else $error("SCL held after busy ended");
  a_shadow_gate: assert property (shadowLoad |-> $past(frameStart) || !$past(acqBusy))
    else $error("shadow load inside a frame");
endmodule
bind i2c_register_access_slave i2c_slave_props #(.EE_WRITE_CYCLES(EE_WRITE_CYCLES)) i_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .sclOut(sclOut), .sclOe(sclOe),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .acqBusy(acqBusy), .frameStart(frameStart),
  .shutterStart(shutterStart), .shadowLoad(shadowLoad), .swResetReq(swResetReq),
  .eeWriteStart(eeWriteStart), .eeBusy(eeBusy), .regAccess(regAccess));

// ===== dv/tb_top.sv
`timescale 1ns/100ps
module tb_top import i2c_regs_pkg::*; ();
  localparam int EE_CYC = 800;
  logic        core_clk   = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        acqBusy    = 1'b0;
  logic        frameStart = 1'b0;
  logic [1:0]  strap      = 2'h0;
  logic        sclLow, sdaLow, sclOe, sdaOe, sclOut, sdaOut;
  logic        shutterStart, shadowLoad, swResetReq, eeWriteStart, eeBusy;
  mem_req_s    regAccess;
  logic [15:0] wrLog[$];
  int          miscompares = 0, total_checks = 0, cyc = 0;
  int          shutCnt = 0, shadowCnt = 0, swCnt = 0, eeCnt = 0;
  wire         sclWire = !(sclLow | sclOe);
  wire         sdaWire = !(sdaLow | sdaOe);
  always #12.5 core_clk = !core_clk;
  i2c_register_access_slave #(.EE_WRITE_CYCLES(EE_CYC)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .sclClk(sclWire), .sclIn(sclWire),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addr_strap_bit_zero(strap[0]), .addr_strap_bit_one(strap[1]), .acqBusy(acqBusy),
    .frameStart(frameStart), .shutterStart(shutterStart), .shadowLoad(shadowLoad),
    .swResetReq(swResetReq), .eeWriteStart(eeWriteStart), .eeBusy(eeBusy),
    .regAccess(regAccess));
  i2c_master_model i_mst (.sclLow(sclLow), .sdaLow(sdaLow), .sclWire(sclWire),
    .sdaWire(sdaWire));
  always @(posedge core_clk) begin
    cyc++;
    if (regAccess.wrEn === 1'b1) wrLog.push_back({regAccess.wrAddr, regAccess.wrData});
    if (shutterStart === 1'b1) shutCnt++;
    if (shadowLoad === 1'b1) shadowCnt++;
    if (swResetReq === 1'b1) swCnt++;
    if (eeWriteStart === 1'b1) eeCnt++;
    if (cyc == 60000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic hwReset();
    sys_rst = 1'b1;
    idle(6);
    sys_rst = 1'b0;
    idle(10);
  endtask
  task automatic send(input logic [7:0] q[$], output logic ok);
    logic a;
    ok = 1'b1;
    i_mst.start();
    foreach (q[i]) begin
      i_mst.wrByte(q[i], a);
      ok = ok & a;
    end
    i_mst.stop();
    idle(4);
  endtask
  task automatic t_write();
    logic ok;
    wrLog = {};
    send({8'h40, 8'hFD, 8'h11, 8'h22, 8'h33}, ok);
    chk("write ack", 16'h1, ok);
    chk("write count", 16'h3, 16'(wrLog.size()));
    chk("write FD", 16'hFD11, wrLog[0]);
    chk("write FE", 16'hFE22, wrLog[1]);
    chk("write FF", 16'hFF33, wrLog[2]);
  endtask
  task automatic t_read();
    logic       a;
    logic [7:0] r[3];
    i_mst.start();
    i_mst.wrByte(8'h40, a);
    i_mst.wrByte(8'hFD, a);
    i_mst.start();
    i_mst.wrByte(8'h41, a);
    chk("read addr ack", 16'h1, a);
    foreach (r[i]) begin
      i_mst.rdByte(i < 2, r[i]);
    end
    i_mst.stop();
    idle(4);
    chk("read FD", 16'h11, r[0]);
    chk("read FE", 16'h22, r[1]);
    chk("read FF", 16'h33, r[2]);
  endtask
  task automatic t_refuse();
    logic ok;
    int   n;
    n = wrLog.size();
    send({8'h42, 8'h01, 8'h77}, ok);
    chk("other addr", 16'h0, ok);
    send({8'hF0, 8'h01, 8'h77}, ok);
    chk("ten-bit header", 16'h0, ok);
    send({GC_ADDR, 8'h05}, ok);
    chk("gc code", 16'h0, ok);
    chk("no write", 16'(n), 16'(wrLog.size()));
  endtask
  task automatic t_frame();
    logic ok;
    acqBusy = 1'b1;
    send({8'h40, SHADOW_LO, 8'h5A}, ok);
    idle(20);
    chk("shadow stored", 16'h905A, wrLog[$]);
    chk("shadow held", 16'h0, 16'(shadowCnt));
    frameStart = 1'b1;
    idle(1);
    frameStart = 1'b0;
    idle(4);
    chk("shadow at frame", 16'h1, 16'(shadowCnt));
    acqBusy = 1'b0;
    send({8'h40, SHUTTER_REG, 8'h01}, ok);
    chk("shutter", 16'h1, 16'(shutCnt));
  endtask
  task automatic t_gc();
    logic ok;
    strap = 2'h3;
    hwReset();
    send({8'h46, 8'h01}, ok);
    chk("strap addr", 16'h1, ok);
    send({8'h40, 8'h01}, ok);
    chk("default addr", 16'h0, ok);
    send({8'h46, ADDR_CFG_REG, 8'h5C}, ok);
    send({GC_ADDR, GC_RELOAD}, ok);
    chk("reload ack", 16'h1, ok);
    send({8'hBE, 8'h01}, ok);
    chk("reloaded addr", 16'h1, ok);
    send({GC_ADDR, GC_SWRESET}, ok);
    idle(10);
    chk("swreset", 16'h1, 16'(swCnt));
    send({8'h46, 8'h01}, ok);
    chk("addr after swreset", 16'h1, ok);
  endtask
  task automatic t_ee();
    logic ok;
    send({8'h46, EE_DATA_REG, 8'hAA}, ok);
    chk("ee start", 16'h1, 16'(eeCnt));
    chk("ee busy", 16'h1, eeBusy);
    send({8'h46, EE_DATA_REG, 8'hBB}, ok);
    chk("stretched ack", 16'h1, ok);
    chk("ee second", 16'h2, 16'(eeCnt));
    idle(EE_CYC + 50);
  endtask
  initial begin
    hwReset();
    t_write();
    t_read();
    t_refuse();
    t_frame();
    t_gc();
    t_ee();
    results();
  end
endmodule
